// ==== shared/desl_pkg.sv ====
/*
 * desl_pkg: register map, widths and zero and one constants shared by the
 * event set / chain / latch block.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
package desl_pkg;
    localparam int unsigned EVT_NUM = 64;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned CODE_W = 6;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned EVT_IDX_W = 6;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_LATCH_LO = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LATCH_HI = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CLEAR_LO = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CLEAR_HI = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MSET_LO = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_MSET_HI = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CHAIN_LO = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CHAIN_HI = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_LO = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_HI = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_LOST_LO = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_LOST_HI = 8'h2C;

    localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [EVT_NUM-1:0] EVT_ZERO = 64'h0000_0000_0000_0000;
    localparam logic [EVT_NUM-1:0] EVT_ONE = 64'h0000_0000_0000_0001;
endpackage : desl_pkg

// ==== rtl/desl_event_latch.sv ====
/*
 * desl_event_latch: per-event trigger latching for a DMA channel
 * controller: external event latch, manual event-set, chained events,
 * lost-trigger flags and a lowest-number-first request issuer.
 * Assumes APB master on the register side, peripheral events as
 * synchronous one-cycle pulses, and a transfer controller that takes a
 * request when req_valid and req_ready are both high.
 * Limitation: requests leave one at a time with one idle cycle between
 * takes, so the peak rate is one event every two clocks.
 */
//
// Behaviour
// (R1) writing one to upper_event_clear clears external latch bits 32..63; zero does nothing
// (R2) writing one to a manual_event_set bit sets it; zero does nothing
// (R3) every set manual bit is a candidate for request submission
// (R4) manual set is valid regardless of enable and independent of the latch
// (R5) event-clear writes never touch manual set bits
// (R6) hardware clears a manual bit only when its request is submitted
// (R7) for manual and chained bits a set beats a same-cycle hardware clear
// (R8) set with clear: lost if already set, else bit stays set and pending
// (R9) writing one to an already set manual bit flags the event lost
// (R10) chaining enabled: six-bit completion code selects the chained bit to set
// (R11) a set chained bit is evaluated for submission like other triggers
// (R12) chained bits ignore the event enables
// (R13) chained bit set by any transfer controller code or early completion path
// (R14) hardware clears a chained bit once its event is serviced
// (R15) chain code for an already set chained bit flags the event lost
// (R16) low register holds events 0..31, high register events 32..63
// (R17) chained registers are read-only, reset to zero, writes ignored
// (R18) external latch captures every peripheral event, enabled or not
// (R19) submitting an enabled external event clears its latch bit
// (R20) pending is enabled latch OR manual bit OR chained bit
`timescale 1ns/10ps
module desl_event_latch #(
    parameter int unsigned NUM_TC = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [desl_pkg::ADDR_W-1:0] paddr,
    input wire logic [desl_pkg::WORD_W-1:0] pwdata,
    output logic [desl_pkg::WORD_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral event pulses, bit n is event n
    input wire logic [desl_pkg::EVT_NUM-1:0] evt_in,
    // completion codes returned by transfer controllers
    input wire logic [NUM_TC-1:0] cc_valid,
    input wire logic [NUM_TC*desl_pkg::CODE_W-1:0] cc_code,
    input wire logic [NUM_TC-1:0] cc_intermediate_chain_enable,
    input wire logic [NUM_TC-1:0] cc_final_chain_enable,
    input wire logic [NUM_TC-1:0] cc_is_final,
    // early completion path of the controller itself
    input wire logic early_valid,
    input wire logic [desl_pkg::CODE_W-1:0] early_code,
    input wire logic early_chain,
    // transfer request toward the transfer controller
    output logic req_valid,
    output logic [desl_pkg::EVT_IDX_W-1:0] req_event,
    input wire logic req_ready
);

    // bounds of the controller count that the code-folding loop serves
    localparam int unsigned TC_MIN = 1;
    localparam int unsigned TC_MAX = 8;

    // elaboration-time refusal of a controller count outside those bounds
    if (NUM_TC < TC_MIN || NUM_TC > TC_MAX) begin : g_bad_num_tc
        $error("desl_event_latch: NUM_TC must lie in 1..8");
    end

    localparam int unsigned EN = desl_pkg::EVT_NUM;
    localparam int unsigned WW = desl_pkg::WORD_W;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [EN-1:0] latch_r;
    logic [EN-1:0] enable_r;
    logic [EN-1:0] mset_r;
    logic [EN-1:0] chain_r;
    logic [EN-1:0] lost_r;

    // one-hot of a six-bit event index
    function automatic logic [EN-1:0] evt_onehot(input logic [desl_pkg::EVT_IDX_W-1:0] idx);
        evt_onehot = desl_pkg::EVT_ONE << idx;
    endfunction : evt_onehot

    // place a 32-bit write word into the low or high half of the event vector
    function automatic logic [EN-1:0] evt_half(input logic [WW-1:0] w, input logic hi);
        evt_half = hi ? {w, desl_pkg::WORD_ZERO} : {desl_pkg::WORD_ZERO, w};
    endfunction : evt_half

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero-wait slave, writes act in the access cycle
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;

    function automatic logic hit(input logic [desl_pkg::ADDR_W-1:0] a,
                                 input logic [desl_pkg::ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    logic [EN-1:0] clr_wr;
    logic [EN-1:0] mset_wr;
    logic [EN-1:0] en_wr;
    always_comb begin
        clr_wr = desl_pkg::EVT_ZERO;
        mset_wr = desl_pkg::EVT_ZERO;
        en_wr = desl_pkg::EVT_ZERO;
        if (wr_acc) begin
            if (hit(paddr, desl_pkg::OFS_CLEAR_LO)) clr_wr = evt_half(pwdata, 1'b0);
            if (hit(paddr, desl_pkg::OFS_CLEAR_HI)) clr_wr = evt_half(pwdata, 1'b1); // R1 R16
            if (hit(paddr, desl_pkg::OFS_MSET_LO)) mset_wr = evt_half(pwdata, 1'b0); // R2
            if (hit(paddr, desl_pkg::OFS_MSET_HI)) mset_wr = evt_half(pwdata, 1'b1); // R16
            // enable register written directly here; no set/clear alias pair
            if (hit(paddr, desl_pkg::OFS_ENABLE_LO)) en_wr = evt_half(pwdata, 1'b0);
            if (hit(paddr, desl_pkg::OFS_ENABLE_HI)) en_wr = evt_half(pwdata, 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chained completion codes from all sources, folded to one vector;
    // two sources naming one event in a cycle give a single set, and the
    // lost flag then only reflects the bit as it stood before the edge
    logic [EN-1:0] chain_set;
    always_comb begin
        chain_set = desl_pkg::EVT_ZERO;
        for (int i = 0; i < NUM_TC; i++) begin
            // chaining only when the entry's matching option is on
            if (cc_valid[i] && (cc_is_final[i] ? cc_final_chain_enable[i]
                                               : cc_intermediate_chain_enable[i])) begin // R13
                chain_set = chain_set | evt_onehot(cc_code[i*desl_pkg::CODE_W +: desl_pkg::CODE_W]); // R10
            end
        end
        if (early_valid && early_chain) begin
            chain_set = chain_set | evt_onehot(early_code); // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pending and selection: lowest event number wins; fixed priority is
    // cheap, but a steadily busy low event can starve the higher ones
    logic [EN-1:0] pending;
    logic [EN-1:0] pend_ext;
    logic [EN-1:0] pend_manual;
    logic [EN-1:0] pend_chain;

    // disabled external events stay latched but are not evaluated
    assign pend_ext = latch_r & enable_r; // R20
    // manual and chained triggers bypass the enables entirely
    assign pend_manual = mset_r; // R3 R4
    assign pend_chain = chain_r; // R11 R12
    assign pending = pend_ext | pend_manual | pend_chain; // R20

    logic sel_any;
    logic [desl_pkg::EVT_IDX_W-1:0] sel_idx;
    always_comb begin
        sel_any = 1'b0;
        sel_idx = '0;
        for (int i = EN - 1; i >= 0; i--) begin
            if (pending[i]) begin
                sel_any = 1'b1;
                sel_idx = desl_pkg::EVT_IDX_W'(i);
            end
        end
    end

    // request handed over this cycle; clears the source bits of that event
    // only enabled external events lose their latch bit on service
    logic take;
    logic [EN-1:0] svc;
    logic [EN-1:0] svc_ext;
    assign take = req_valid && req_ready;
    assign svc = take ? evt_onehot(req_event) : desl_pkg::EVT_ZERO;
    assign svc_ext = svc & enable_r; // R19

    ////////////////////////////////////////////////////////////////////////
    // request register: held stable until accepted, then re-chosen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_valid <= 1'b0;
            req_event <= '0;
        end else if (!req_valid || take) begin
            // after a take the register idles one cycle: the bit just served
            // is still in pending until the clear lands, and would be sent twice
            req_valid <= sel_any && !take;
            req_event <= sel_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external latch next value: a new event beats a same-cycle clear, so
    // a pulse landing on a software clear or a service is never dropped
    logic [EN-1:0] latch_nxt;
    always_comb begin
        latch_nxt = latch_r;
        latch_nxt = latch_nxt & ~clr_wr; // R1
        latch_nxt = latch_nxt & ~svc_ext; // R19
        latch_nxt = latch_nxt | evt_in; // R18
    end

    // external latch register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r <= desl_pkg::EVT_ZERO;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    // event enables: a direct write replaces only the addressed half
    logic en_hit;
    logic [EN-1:0] en_keep;
    logic [EN-1:0] enable_nxt;
    assign en_hit = wr_acc && (hit(paddr, desl_pkg::OFS_ENABLE_LO)
                               || hit(paddr, desl_pkg::OFS_ENABLE_HI));
    always_comb begin
        en_keep = ~desl_pkg::EVT_ZERO;
        if (en_hit) begin
            // clear the half being written, the other half stays
            en_keep = ~evt_half(~desl_pkg::WORD_ZERO, hit(paddr, desl_pkg::OFS_ENABLE_HI));
        end
        enable_nxt = (enable_r & en_keep) | en_wr;
    end

    // event enable register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= desl_pkg::EVT_ZERO;
        end else begin
            enable_r <= enable_nxt;
        end
    end

    // manual set next value: clear-register writes never enter it, so
    // software has no path to withdraw a manual trigger
    logic [EN-1:0] mset_nxt;
    always_comb begin
        // service clears first, so a same-cycle write of one wins
        mset_nxt = mset_r & ~svc; // R6
        mset_nxt = mset_nxt | mset_wr; // R2 R5 R7
    end

    // manual set register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mset_r <= desl_pkg::EVT_ZERO;
        end else begin
            mset_r <= mset_nxt;
        end
    end

    // chained next value: no software write path, so chain register writes
    // decode to nothing and are ignored
    logic [EN-1:0] chain_nxt;
    always_comb begin
        // service clears first, so a same-cycle chain code wins
        chain_nxt = chain_r & ~svc; // R14
        chain_nxt = chain_nxt | chain_set; // R7 R12
    end

    // chained register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_r <= desl_pkg::EVT_ZERO; // R17
        end else begin
            chain_r <= chain_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lost flags: a set landing on a bit already set; sticky, write-1-to-clear
    logic [EN-1:0] lost_set;
    logic [EN-1:0] lost_clr;
    logic [EN-1:0] lost_mset;
    logic [EN-1:0] lost_chain;
    logic [EN-1:0] lost_nxt;
    // a collision is judged against the bit as it stood before this edge,
    // so a same-cycle service still reports the lost trigger
    assign lost_mset = mset_wr & mset_r; // R8 R9
    assign lost_chain = chain_set & chain_r; // R8 R15
    assign lost_set = lost_mset | lost_chain;
    // set wins over a same-cycle software clear
    assign lost_nxt = (lost_r & ~lost_clr) | lost_set; // R8
    always_comb begin
        lost_clr = desl_pkg::EVT_ZERO;
        if (wr_acc && hit(paddr, desl_pkg::OFS_LOST_LO)) lost_clr = evt_half(pwdata, 1'b0);
        if (wr_acc && hit(paddr, desl_pkg::OFS_LOST_HI)) lost_clr = evt_half(pwdata, 1'b1);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lost_r <= desl_pkg::EVT_ZERO;
        end else begin
            lost_r <= lost_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb read data and answer, registered in the setup cycle
    // write-only clear registers read back as zero
    logic [WW-1:0] rd_mux;
    logic known;
    always_comb begin
        rd_mux = desl_pkg::WORD_ZERO;
        known = 1'b1;
        case (paddr)
            desl_pkg::OFS_LATCH_LO: rd_mux = latch_r[WW-1:0];
            desl_pkg::OFS_LATCH_HI: rd_mux = latch_r[EN-1:WW];
            desl_pkg::OFS_CLEAR_LO: rd_mux = desl_pkg::WORD_ZERO;
            desl_pkg::OFS_CLEAR_HI: rd_mux = desl_pkg::WORD_ZERO;
            desl_pkg::OFS_MSET_LO: rd_mux = mset_r[WW-1:0];
            desl_pkg::OFS_MSET_HI: rd_mux = mset_r[EN-1:WW];
            desl_pkg::OFS_CHAIN_LO: rd_mux = chain_r[WW-1:0]; // R17
            desl_pkg::OFS_CHAIN_HI: rd_mux = chain_r[EN-1:WW];
            desl_pkg::OFS_ENABLE_LO: rd_mux = enable_r[WW-1:0];
            desl_pkg::OFS_ENABLE_HI: rd_mux = enable_r[EN-1:WW];
            desl_pkg::OFS_LOST_LO: rd_mux = lost_r[WW-1:0];
            desl_pkg::OFS_LOST_HI: rd_mux = lost_r[EN-1:WW];
            default: known = 1'b0;
        endcase
    end

    // setup phase of a transfer; the answer is prepared here so that it
    // stands for exactly the one access cycle that follows, at the cost
    // of reading the registers one cycle before the access edge
    logic setup;
    assign setup = psel && !penable;

    // pready high throughout the access cycle: every transfer takes two cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= desl_pkg::WORD_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !known;
            prdata <= (setup && !pwrite) ? rd_mux : desl_pkg::WORD_ZERO;
        end
    end

endmodule : desl_event_latch

// ==== bench/desl_event_latch_properties.sv ====
/* port-level properties of the event set / chain / latch block.
   assumes a bind from the bench top; one clock, async active-low reset. */
`timescale 1ns/10ps
module desl_event_latch_properties #(
    parameter int unsigned NUM_TC = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [desl_pkg::ADDR_W-1:0] paddr,
    input wire logic [desl_pkg::WORD_W-1:0] pwdata,
    input wire logic [desl_pkg::WORD_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_TC-1:0] cc_valid,
    input wire logic [NUM_TC-1:0] cc_final_chain_enable,
    input wire logic [NUM_TC-1:0] cc_is_final,
    input wire logic early_valid,
    input wire logic early_chain,
    input wire logic req_valid,
    input wire logic [desl_pkg::EVT_IDX_W-1:0] req_event,
    input wire logic req_ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    // bus phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    // slack of three edges covers the forced idle cycle after a take
    AST_MSET_REQ: assert property (s_access ##0 (pwrite && paddr == desl_pkg::OFS_MSET_LO
        && pwdata != desl_pkg::WORD_ZERO) |-> ##[1:3] req_valid) else $error("manual set ignored");
    AST_CHAIN_REQ: assert property ((cc_valid & cc_is_final & cc_final_chain_enable) != 0
        |-> ##[1:3] req_valid) else $error("chain code ignored");
    AST_EARLY_REQ: assert property (early_valid && early_chain |-> ##[1:3] req_valid)
        else $error("early chain ignored");
    AST_REQ_HOLD: assert property (req_valid && !req_ready |=> req_valid && $stable(req_event))
        else $error("request dropped before take");
    AST_REQ_GAP: assert property (req_valid && req_ready |=> !req_valid)
        else $error("request not retired");
    AST_APB_ANSWER: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    AST_UNMAPPED: assert property (s_access ##0 (paddr > desl_pkg::OFS_LOST_HI) |-> pslverr)
        else $error("unmapped access accepted");
    AST_ERR_ONLY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_RD_IDLE: assert property (!pready |-> prdata == desl_pkg::WORD_ZERO)
        else $error("read data outside access");
    AST_CHAIN_MAPPED: assert property (s_access ##0 (paddr == desl_pkg::OFS_CHAIN_LO) |-> !pslverr)
        else $error("chain register refused");
endmodule : desl_event_latch_properties

// ==== bench/desl_tc_model.sv ====
/* transfer controller stand-in: takes requests after a set stall and
   returns a chain code when a chosen event is taken. assumes one clock. */
`timescale 1ns/10ps
module desl_tc_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic [5:0] req_event,
    output logic req_ready,
    output logic [1:0] cc_valid,
    output logic [11:0] cc_code,
    input wire logic [7:0] stall,
    input wire logic [5:0] chain_src,
    input wire logic [5:0] chain_code,
    output logic [5:0] last_ev,
    output logic [7:0] takes
);
    logic [7:0] wait_r;
    // ready only once the request has waited out the stall
    assign req_ready = req_valid && wait_r >= stall;
    ////////////////////////////////////////////////////////////////////////////
    // take, log and chain; idle code toggles so stale values never look valid
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 8'h00;
            takes <= 8'h00;
            last_ev <= 6'h00;
            cc_valid <= 2'h0;
            cc_code <= 12'h000;
        end else begin
            cc_valid <= 2'h0;
            cc_code <= ~cc_code;
            wait_r <= (req_valid && !req_ready) ? wait_r + 8'h01 : 8'h00;
            if (req_ready) begin
                takes <= takes + 8'h01;
                last_ev <= req_event;
                if (req_event == chain_src) begin
                    cc_valid <= 2'h1;
                    cc_code <= {6'h00, chain_code};
                end
            end
        end
    end
endmodule : desl_tc_model

// ==== bench/desl_event_latch_test.sv ====
/* self-checking bench: APB register tasks, a controller model, and
   scenarios for set, clear, chain and lost flags. assumes nothing else. */
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, e); end end
module desl_event_latch_test;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00, stall = 8'h28, takes;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [63:0] evt_in = 64'h0;
    logic [1:0] cc_valid;
    logic [1:0] cc_ien = 2'h0, cc_fin = 2'h3;
    logic [11:0] cc_code;
    logic early_valid = 1'b0, early_chain = 1'b0, req_valid, req_ready;
    logic [5:0] early_code = 6'h00, chain_src = 6'h3F, chain_code = 6'h00, last_ev, req_event;
    int checked = 0, fail_count = 0;
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    desl_event_latch #(.NUM_TC(2)) dut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt_in(evt_in), .cc_valid(cc_valid),
        .cc_code(cc_code), .cc_intermediate_chain_enable(cc_ien), .cc_final_chain_enable(2'h3),
        .cc_is_final(cc_fin), .early_valid(early_valid), .early_code(early_code),
        .early_chain(early_chain), .req_valid(req_valid), .req_event(req_event),
        .req_ready(req_ready));
    desl_tc_model tc (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_event(req_event),
        .req_ready(req_ready), .cc_valid(cc_valid), .cc_code(cc_code), .stall(stall),
        .chain_src(chain_src), .chain_code(chain_code), .last_ev(last_ev), .takes(takes));
    ////////////////////////////////////////////////////////////////////////////
    // one apb transfer; holds everything until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        `CHK(pready, 1'b1)
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        `CHK(q, e)
    endtask : rd
    // waits for the next take by the controller and checks its event
    task automatic take(input logic [5:0] e);
        logic [7:0] n;
        n = takes;
        for (int i = 0; i < 200 && takes == n; i++) @(posedge clk);
        `CHK(takes != n, 1'b1)
        `CHK(last_ev, e)
    endtask : take
    task finish_test;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        fail_count++;
        finish_test;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(desl_pkg::OFS_CHAIN_HI, 32'h0);
        apb(desl_pkg::OFS_MSET_HI, 1'b1, 32'h2);
        rd(desl_pkg::OFS_MSET_HI, 32'h2);
        apb(desl_pkg::OFS_CLEAR_HI, 1'b1, 32'hFFFF_FFFF);
        rd(desl_pkg::OFS_MSET_HI, 32'h2);
        apb(desl_pkg::OFS_MSET_HI, 1'b1, 32'h2);
        rd(desl_pkg::OFS_LOST_HI, 32'h2);
        take(6'h21);
        rd(desl_pkg::OFS_MSET_HI, 32'h0);
        stall <= 8'h00;
        apb(desl_pkg::OFS_ENABLE_LO, 1'b1, 32'h20);
        evt_in <= 64'h0000_0004_0000_0060;
        @(posedge clk) evt_in <= 64'h0;
        take(6'h05);
        rd(desl_pkg::OFS_LATCH_LO, 32'h40);
        rd(desl_pkg::OFS_ENABLE_LO, 32'h20);
        apb(desl_pkg::OFS_CLEAR_LO, 1'b1, 32'h40);
        rd(desl_pkg::OFS_LATCH_LO, 32'h0);
        rd(desl_pkg::OFS_LATCH_HI, 32'h4);
        apb(desl_pkg::OFS_CLEAR_HI, 1'b1, 32'h4);
        rd(desl_pkg::OFS_LATCH_HI, 32'h0);
        chain_src <= 6'h03;
        chain_code <= 6'h28;
        apb(desl_pkg::OFS_MSET_LO, 1'b1, 32'h8);
        take(6'h03);
        take(6'h28);
        rd(desl_pkg::OFS_CHAIN_HI, 32'h0);
        cc_fin <= 2'h0;
        cc_ien <= 2'h3;
        apb(desl_pkg::OFS_MSET_LO, 1'b1, 32'h8);
        take(6'h03);
        take(6'h28);
        apb(desl_pkg::OFS_CHAIN_LO, 1'b1, 32'hFFFF_FFFF);
        rd(desl_pkg::OFS_CHAIN_LO, 32'h0);
        stall <= 8'h28;
        early_valid <= 1'b1;
        early_chain <= 1'b1;
        early_code <= 6'h09;
        repeat (2) @(posedge clk);
        early_valid <= 1'b0;
        rd(desl_pkg::OFS_CHAIN_LO, 32'h200);
        rd(desl_pkg::OFS_LOST_LO, 32'h200);
        apb(desl_pkg::OFS_LOST_HI, 1'b1, 32'h2);
        rd(desl_pkg::OFS_LOST_HI, 32'h0);
        take(6'h09);
        rd(8'h40, 32'h0);
        finish_test;
    end
endmodule : desl_event_latch_test
bind desl_event_latch desl_event_latch_properties #(.NUM_TC(NUM_TC)) u_props (.clk(clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cc_valid(cc_valid),
    .cc_final_chain_enable(cc_final_chain_enable), .cc_is_final(cc_is_final),
    .early_valid(early_valid), .early_chain(early_chain), .req_valid(req_valid),
    .req_event(req_event), .req_ready(req_ready));
